// ---- skip_seq_defs.svh ----
/*
 * Offsets-free constant set for the sequencing core: widths, instruction
 * identifiers, stack geometry and slot lengths in clock cycles.
 * Assumes it is included by bare name from the package and design files.
 */
`ifndef SKIP_SEQ_DEFS_SVH
`define SKIP_SEQ_DEFS_SVH

`define PC_W 14
`define PC_HALF_W 7
`define STACK_DEPTH 8
`define SP_W 3
`define SP_RESET 3'h7
`define DP_W 10
`define X_W 4
`define Y_W 4
`define Z_W 2
`define DR_W 3
`define ACC_W 4
`define OP_W 7
`define OP_COUNT 7'h6e
`define PC_RESET 14'h0000

// Identifiers of the instructions that sequencing treats specially.
`define OP_TABLE_REF 7'h00
`define OP_RETURN 7'h01
`define OP_RETURN_SKIP 7'h02
`define OP_CALL 7'h03
`define OP_JUMP 7'h04

// Slot lengths, in cycles of ref_clk.
`define LEN_W 2
`define LEN_TABLE_REF 2'h3
`define LEN_RETURN 2'h2
`define LEN_CALL 2'h2
`define LEN_PLAIN 2'h1
`define LEN_NULL_SHORT 2'h1

`endif

// ---- skip_seq_pkg.sv ----
/*
 * Types shared by the sequencing core and its call stack.
 * Assumes skip_seq_defs.svh is on the include path.
 */
`include "skip_seq_defs.svh"

package skip_seq_pkg;
	typedef logic [`PC_W-1:0] pc_t;
	typedef logic [`SP_W-1:0] sp_t;
	typedef logic [`OP_W-1:0] op_t;
	typedef logic [`LEN_W-1:0] len_t;
	typedef enum logic {SL_FETCH, SL_BUSY} slot_e;
endpackage

// ---- stack_if.sv ----
/*
 * Carrier between the sequencing core and the return-address stack.
 * Assumes both ends share ref_clk.
 */
`timescale 1ns/1ps

interface stack_if;
	import skip_seq_pkg::*;
	logic push;
	logic pop;
	pc_t push_addr;
	pc_t top_addr;
	sp_t sp;
	modport core (output push, output pop, output push_addr, input top_addr, input sp);
	modport stack (input push, input pop, input push_addr, output top_addr, output sp);
endinterface

// ---- call_stack.sv ----
/*
 * Return-address stack of eight program counter values.
 * Assumes push and pop are never raised in the same cycle.
 */
`timescale 1ns/1ps
`include "skip_seq_defs.svh"

module call_stack
	import skip_seq_pkg::*;
(
	// Clock and reset.
	input wire logic ref_clk,
	input wire logic rst,
	// Core side.
	stack_if.stack stk
);
	pc_t mem [`STACK_DEPTH];
	sp_t sp_ff;
	wire sp_t sp_up = sp_ff + `SP_W'(1);
	wire sp_t sp_down = sp_ff - `SP_W'(1);

	// Wraps silently past eight entries, as the stack pointer is only three bits.
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			sp_ff <= `SP_RESET;
		end else if (stk.push) begin
			sp_ff <= sp_up;
		end else if (stk.pop) begin
			sp_ff <= sp_down;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (stk.push) begin
			mem[sp_up] <= stk.push_addr;
		end
	end

	assign stk.top_addr = mem[sp_ff];
	assign stk.sp = sp_ff;

	a_stack_push_sp: assert property (@(posedge ref_clk) disable iff (rst)
		stk.push |=> sp_ff == $past(sp_up))
		else $error("stack pointer did not advance on push");
	a_stack_pop_sp: assert property (@(posedge ref_clk) disable iff (rst)
		stk.pop |=> sp_ff == $past(sp_down))
		else $error("stack pointer did not retreat on pop");
	a_stack_push_data: assert property (@(posedge ref_clk) disable iff (rst)
		stk.push |=> stk.top_addr == $past(stk.push_addr))
		else $error("pushed address not on stack top");
endmodule

// ---- skip_sequencing_core.sv ----
/*
 * Program sequencing core: slot timing, skip nullification, program counter,
 * call stack control and data pointer assembly.
 * Assumes an outside decoder presents the current instruction's identifier
 * while slot_start is high and its operand until slot_last, and that the datapath raises
 * skip_cond on the last cycle of an executed slot whose condition holds.
 */
// Contract
// - The decoder accepts 110 instruction identifiers; others are flagged illegal.
// - A satisfied skip nullifies the next instruction: fetched, effects suppressed.
// - A taken skip does not add two; the counter steps once per slot.
// - Any other nullified instruction takes as many cycles as when executed.
// - Nullified table call, return or return-with-skip takes exactly one cycle.
// - The program counter is 14 bits wide.
// - The counter splits into 7-bit page and 7-bit in-page halves.
// - The return stack holds eight 14-bit program counter values.
// - The stack pointer is 3 bits wide.
// - The 10-bit data pointer concatenates index registers of 4, 4, 2 bits.
`timescale 1ns/1ps
`include "skip_seq_defs.svh"

module skip_sequencing_core
	import skip_seq_pkg::*;
(
	// Clock and reset.
	input wire logic ref_clk,
	input wire logic rst,
	// Decoded instruction.
	input wire logic [`OP_W-1:0] op_id,
	input wire logic [`PC_W-1:0] op_target,
	// Datapath.
	input wire logic skip_cond,
	input wire logic [`DR_W-1:0] dr_val,
	input wire logic [`ACC_W-1:0] acc_val,
	input wire logic [`X_W-1:0] x_val,
	input wire logic [`Y_W-1:0] y_val,
	input wire logic [`Z_W-1:0] z_val,
	// Sequencing status.
	output logic [`PC_W-1:0] pc_out,
	output logic [`PC_HALF_W-1:0] pc_high,
	output logic [`PC_HALF_W-1:0] pc_low,
	output logic slot_start,
	output logic slot_last,
	output logic exec_en,
	output logic illegal_op,
	output logic skip_pending,
	output logic table_read,
	output logic [`SP_W-1:0] stack_ptr,
	output logic [`DP_W-1:0] data_pointer
);
	stack_if stk ();

	call_stack u_stack (
		.ref_clk(ref_clk),
		.rst(rst),
		.stk(stk)
	);

	slot_e state_ff;
	op_t op_ff;
	len_t cnt_ff;
	pc_t pc_ff;
	logic skip_ff;
	logic illegal_ff;
	logic table_ff;
	logic [`DP_W-1:0] dp_ff;

	wire op_t cur_op = (state_ff == SL_FETCH) ? op_id : op_ff;
	wire legal = cur_op < `OP_COUNT;
	wire is_table = legal && (cur_op == `OP_TABLE_REF);
	wire is_ret = legal && (cur_op == `OP_RETURN);
	wire is_rets = legal && (cur_op == `OP_RETURN_SKIP);
	wire is_call = legal && (cur_op == `OP_CALL);
	wire is_jump = legal && (cur_op == `OP_JUMP);
	wire is_short_null = is_table || is_ret || is_rets;
	wire nullified = skip_ff;

	// Executed length first; a nullified slot keeps it except for three ops.
	wire len_t len_exec = is_table ? `LEN_TABLE_REF :
		(is_ret || is_rets) ? `LEN_RETURN :
		is_call ? `LEN_CALL : `LEN_PLAIN;
	wire len_t len_slot = (nullified && is_short_null) ? `LEN_NULL_SHORT : len_exec;
	wire last = cnt_ff == len_slot - `LEN_W'(1);
	wire run = !nullified && legal;

	wire pc_t pc_inc = pc_ff + `PC_W'(1);
	wire pc_t table_addr = {op_target[`PC_HALF_W-1:0], dr_val, acc_val};

	// Table call pushes in its first cycle and pops in its last.
	assign stk.push = run && ((is_call && last) || (is_table && cnt_ff == `LEN_W'(0)));
	assign stk.push_addr = pc_inc;
	assign stk.pop = run && last && (is_ret || is_rets || is_table);

	wire pc_t pc_next = !run ? pc_inc :
		(is_ret || is_rets || is_table) ? stk.top_addr :
		(is_call || is_jump) ? op_target : pc_inc;

	// A new skip may only be raised by an executed slot, so set never meets clear.
	wire skip_set = run && last && (skip_cond || is_rets);
	wire skip_clr = nullified && last;

	// The identifier is copied on every edge that does not end the slot, so the
	// length and decode stay fixed even if the decoder moves on after the start.
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			state_ff <= SL_FETCH;
			cnt_ff <= `LEN_W'(0);
			op_ff <= `OP_W'(0);
		end else if (last) begin
			state_ff <= SL_FETCH;
			cnt_ff <= `LEN_W'(0);
		end else begin
			state_ff <= SL_BUSY;
			cnt_ff <= cnt_ff + `LEN_W'(1);
			op_ff <= cur_op;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (rst) begin
			pc_ff <= `PC_RESET;
		end else if (last) begin
			pc_ff <= pc_next;
		end else if (run && is_table && cnt_ff == `LEN_W'(0)) begin
			pc_ff <= table_addr;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (rst) begin
			skip_ff <= 1'b0;
		end else if (skip_set) begin
			skip_ff <= 1'b1;
		end else if (skip_clr) begin
			skip_ff <= 1'b0;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (rst) begin
			illegal_ff <= 1'b0;
			table_ff <= 1'b0;
			dp_ff <= `DP_W'(0);
		end else begin
			illegal_ff <= (state_ff == SL_FETCH) && !legal;
			table_ff <= run && is_table && cnt_ff == `LEN_W'(0);
			dp_ff <= {z_val, x_val, y_val};
		end
	end

	assign pc_out = pc_ff;
	assign pc_high = pc_ff[`PC_W-1:`PC_HALF_W];
	assign pc_low = pc_ff[`PC_HALF_W-1:0];
	assign slot_start = state_ff == SL_FETCH;
	assign slot_last = last;
	assign exec_en = run;
	assign illegal_op = illegal_ff;
	assign skip_pending = skip_ff;
	assign table_read = table_ff;
	assign stack_ptr = stk.sp;
	assign data_pointer = dp_ff;

	// A slot that starts while a skip is pending is the one being nullified.
	sequence s_null_start;
		slot_start && skip_ff;
	endsequence
	sequence s_exec_start;
		slot_start && exec_en;
	endsequence
	sequence s_two_cycles;
		!slot_last ##1 slot_last;
	endsequence
	sequence s_three_cycles;
		!slot_last ##1 !slot_last ##1 slot_last;
	endsequence

	a_illegal_flag: assert property (@(posedge ref_clk) disable iff (rst)
		slot_start && op_id >= `OP_COUNT |=> illegal_op)
		else $error("out of range identifier not flagged");
	a_null_no_exec: assert property (@(posedge ref_clk) disable iff (rst)
		s_null_start |-> !exec_en && !stk.push)
		else $error("nullified slot had effects");
	a_null_pc_step: assert property (@(posedge ref_clk) disable iff (rst)
		skip_ff && slot_last |=> pc_out == $past(pc_out) + `PC_W'(1))
		else $error("nullified slot did not step the counter by one");
	a_null_call_len: assert property (@(posedge ref_clk) disable iff (rst)
		s_null_start ##0 (op_id == `OP_CALL) |-> s_two_cycles)
		else $error("nullified call changed its cycle count");
	a_null_ret_len: assert property (@(posedge ref_clk) disable iff (rst)
		s_null_start ##0 (op_id == `OP_RETURN || op_id == `OP_RETURN_SKIP
		|| op_id == `OP_TABLE_REF) |-> slot_last)
		else $error("nullified table call or return not one cycle");
	a_pc_halves: assert property (@(posedge ref_clk) disable iff (rst)
		{pc_high, pc_low} == pc_out)
		else $error("counter halves disagree with counter");
	a_dp_concat: assert property (@(posedge ref_clk) disable iff (rst)
		1'b1 |=> data_pointer == {$past(z_val), $past(x_val), $past(y_val)})
		else $error("data pointer not assembled from index registers");
	a_skip_set: assert property (@(posedge ref_clk) disable iff (rst)
		exec_en && slot_last && skip_cond |=> skip_pending ##0 slot_start)
		else $error("satisfied skip did not raise pending flag");
	a_skip_clear: assert property (@(posedge ref_clk) disable iff (rst)
		skip_pending && slot_last |=> !skip_pending)
		else $error("pending flag not cleared after nullified slot");
	a_slot_order: assert property (@(posedge ref_clk) disable iff (rst)
		slot_last |=> slot_start)
		else $error("slots not back to back");
	a_table_len: assert property (@(posedge ref_clk) disable iff (rst)
		s_exec_start ##0 (op_id == `OP_TABLE_REF) |-> s_three_cycles)
		else $error("executed table call not three cycles");
	// The page comes from the operand and the in-page address from the two registers.
	a_table_read: assert property (@(posedge ref_clk) disable iff (rst)
		s_exec_start ##0 (op_id == `OP_TABLE_REF) |=> table_read
		&& pc_high == $past(op_target[`PC_HALF_W-1:0])
		&& pc_low == {$past(dr_val), $past(acc_val)})
		else $error("table call address not formed from page and registers");
	a_call_push: assert property (@(posedge ref_clk) disable iff (rst)
		exec_en && slot_last && is_call
		|=> stack_ptr == $past(stack_ptr) + `SP_W'(1) && pc_out == $past(op_target))
		else $error("call did not push and jump");
	a_rets_skip: assert property (@(posedge ref_clk) disable iff (rst)
		exec_en && slot_last && is_rets |=> skip_pending)
		else $error("return with skip did not raise pending flag");
	a_illegal_nop: assert property (@(posedge ref_clk) disable iff (rst)
		slot_start && op_id >= `OP_COUNT |-> !exec_en && slot_last)
		else $error("out of range identifier was executed");
endmodule

// ---- testbench.sv ----
/*
 * Self-checking bench for the sequencing core: a slot-level model with
 * integers and a stack array predicts every slot, directed then random.
 * Assumes the core's hand-over timing: one slot per op_id, held all slot.
 */
`timescale 1ns/1ps
`define CHK(n, g, e) begin compares++; if ((g) !== (e)) begin failures++; \
	$display("Error %s expected %0h seen %0h", n, e, g); end end

module testbench;
	logic ref_clk = 0, rst = 1, skip_cond = 0;
	logic [6:0] op_id = 7'h05;
	logic [13:0] op_target = 14'h0000;
	logic [2:0] dr_val = 0;
	logic [3:0] acc_val = 0, x_val = 0, y_val = 0;
	logic [1:0] z_val = 0;
	logic [13:0] pc_out;
	logic [6:0] pc_high, pc_low;
	logic slot_start, slot_last, exec_en, illegal_op, skip_pending, table_read;
	logic [2:0] stack_ptr;
	logic [9:0] data_pointer;
	int failures = 0, compares = 0;
	int pc = 0, sp = 7, skp = 0, dpv = 0, prev_ill = 0, depth = 0, k, c, op;
	int stk [8];
	bit [31:0] seed = 32'h0000_6bd8;

	skip_sequencing_core uut (.ref_clk(ref_clk), .rst(rst), .op_id(op_id),
		.op_target(op_target), .skip_cond(skip_cond), .dr_val(dr_val), .acc_val(acc_val),
		.x_val(x_val), .y_val(y_val), .z_val(z_val), .pc_out(pc_out), .pc_high(pc_high),
		.pc_low(pc_low), .slot_start(slot_start), .slot_last(slot_last), .exec_en(exec_en),
		.illegal_op(illegal_op), .skip_pending(skip_pending), .table_read(table_read),
		.stack_ptr(stack_ptr), .data_pointer(data_pointer));

	always #12.5 ref_clk = ~ref_clk;

	function automatic bit [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction

	task automatic summarize();
		$display("compares %0d failures %0d", compares, failures);
		if (failures == 0 && compares > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask

	// One instruction slot; the model decides its length before driving it.
	task automatic run_slot(input int op, input int tgt, input int sc);
		int len, ex, leg, nul, i;
		bit [31:0] r;
		leg = op < 110;
		nul = skp;
		ex = leg && !nul;
		r = rnd();
		len = 1;
		if (leg && op == 0) len = nul ? 1 : 3;
		if (leg && (op == 1 || op == 2)) len = nul ? 1 : 2;
		if (leg && op == 3) len = 2;
		@(posedge ref_clk);
		rst <= 1'b0;
		op_id <= op[6:0];
		op_target <= tgt[13:0];
		skip_cond <= sc[0];
		x_val <= r[3:0];
		y_val <= r[7:4];
		z_val <= r[9:8];
		dr_val <= r[12:10];
		acc_val <= r[16:13];
		#1;
		`CHK("exec_en", exec_en, ex)
		`CHK("pc_out", pc_out, pc)
		`CHK("pc_high", pc_high, pc >> 7)
		`CHK("pc_low", pc_low, pc & 127)
		`CHK("stack_ptr", stack_ptr, sp)
		`CHK("skip_pending", skip_pending, nul)
		`CHK("illegal_op", illegal_op, prev_ill)
		`CHK("data_pointer", data_pointer, dpv)
		for (i = 0; i < len; i++) begin
			if (i > 0) begin
				@(posedge ref_clk);
				#1;
			end
			`CHK("slot_start", slot_start, i == 0)
			`CHK("slot_last", slot_last, i == len - 1)
			`CHK("table_read", table_read, op == 0 && ex && i == 1)
			if (op == 0 && ex && i == 1) begin
				`CHK("table_addr", pc_out, ((tgt & 127) << 7) | {r[12:10], r[16:13]})
			end
		end
		dpv = {r[9:8], r[3:0], r[7:4]};
		prev_ill = !leg;
		if (ex && op == 3) begin
			sp = (sp + 1) % 8;
			stk[sp] = (pc + 1) & 16383;
			depth++;
			pc = tgt & 16383;
		end else if (ex && (op == 1 || op == 2)) begin
			pc = stk[sp];
			sp = (sp + 7) % 8;
			depth--;
		end else if (ex && op == 4) begin
			pc = tgt & 16383;
		end else begin
			pc = (pc + 1) & 16383;
		end
		skp = ex && (sc || op == 2);
	endtask

	initial begin
		repeat (20000) @(posedge ref_clk);
		failures++;
		summarize();
	end

	initial begin
		repeat (11) @(posedge ref_clk);
		run_slot(109, 0, 0);
		run_slot(110, 0, 1);
		run_slot(3, 14'h2a55, 1);
		run_slot(0, 14'h0011, 0);
		run_slot(2, 0, 0);
		run_slot(1, 0, 0);
		run_slot(0, 14'h007f, 1);
		run_slot(3, 14'h1234, 0);
		run_slot(3, 14'h0100, 0);
		run_slot(2, 0, 0);
		$display("test directed done");
		for (k = 0; k < 300; k++) begin
			c = rnd() % 8;
			case (c)
				0: op = 0;
				1: op = depth < 7 ? 3 : 5;
				2: op = depth > 0 ? 1 : 5;
				3: op = depth > 0 ? 2 : 5;
				4: op = 4;
				5: op = 110 + rnd() % 18;
				default: op = 5 + rnd() % 105;
			endcase
			run_slot(op, rnd() & 16383, rnd() & 1);
		end
		$display("test random done");
		summarize();
	end
endmodule
